// file: hw/dnpi_pkg.sv
package dnpi_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_HZ        = 40_000_000;
   localparam int SAMPLE_MS     = 20;
   localparam int TUNE_MS       = 100;
   localparam int SAMPLE_CYC    = CLK_HZ / 1000 * SAMPLE_MS;
   localparam int TUNE_CYC      = CLK_HZ / 1000 * TUNE_MS;

   // ************************************************************
   // register image
   // ************************************************************
   localparam int ADDR_W        = 8;
   localparam int DATA_W        = 16;
   localparam logic [7:0] STATUS_IDX = 8'h00;
   localparam logic [7:0] CTRL_IDX   = 8'h20;
   localparam logic [7:0] CFG_IDX    = 8'h3e;
   localparam logic [7:0] PROT_IDX   = 8'hff;
   localparam logic [7:0] CMD_BASE   = 8'h20;
   localparam logic [7:0] RPL_BASE   = 8'h00;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   // status register 0 bits
   localparam int ST_READY_BIT  = 0;
   localparam int ST_FAULT_BIT  = 2;
   localparam int ST_SYNC_BIT   = 7;
   localparam int ST_COAST_BIT  = 10;
   localparam int ST_ILOCK_BIT  = 11;
   // control register bits
   localparam int CT_RUN_BIT    = 0;
   localparam int CT_STOP_BIT   = 1;
   localparam int CT_JOG_BIT    = 2;
   localparam int CT_TUNE_BIT   = 14;
   localparam int CT_SYNC_BIT   = 15;
   // config register bits
   localparam int CF_FULL_BIT   = 0;
   localparam int CF_CMDX_BIT   = 1;
   localparam int CF_RPLX_BIT   = 2;

   // poll lengths in words
   localparam logic [4:0] CMD_SHORT = 5'h04;
   localparam logic [4:0] CMD_LONG  = 5'h1a;
   localparam logic [3:0] RPL_SHORT = 4'h8;
   localparam logic [3:0] RPL_LONG  = 4'hd;

   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } dnpi_bus_type;

   typedef struct packed {
      logic fault;
      logic panel_stop;
      logic coast_brake_stop_input;
      logic interlock;
   } dnpi_pins_type;

   typedef enum logic [1:0] {
      RPL_IDLE = 2'b01,
      RPL_SEND = 2'b10
   } dnpi_rpl_type;

endpackage

// file: hw/dnpi_reg_mem.sv
`timescale 1ns/1ps
module dnpi_reg_mem
   import dnpi_pkg::*;
#(
   parameter int AW = 8,
   parameter int DW = 16
) (
   input  wire logic          core_clk_in,
   input  wire logic          rst_in,
   input  wire logic [AW-1:0] a_addr_in,
   input  wire logic          a_we_in,
   input  wire logic          a_re_in,
   input  wire logic [DW-1:0] a_wdata_in,
   input  wire logic          a_ovr_in,
   input  wire logic [DW-1:0] a_ovr_data_in,
   output logic      [DW-1:0] a_rdata_out,
   input  wire logic [AW-1:0] b_addr_in,
   input  wire logic          b_we_in,
   input  wire logic [DW-1:0] b_wdata_in,
   input  wire logic [AW-1:0] c_addr_in,
   input  wire logic          c_re_in,
   input  wire logic          c_ovr_in,
   input  wire logic [DW-1:0] c_ovr_data_in,
   output logic      [DW-1:0] c_rdata_out
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // one process owns the array; port b wins a same-address collision
   always_ff @(posedge core_clk_in) begin
      if (a_we_in) begin
         mem[a_addr_in] <= a_wdata_in;
      end
      if (b_we_in) begin
         mem[b_addr_in] <= b_wdata_in;
      end
   end

   // read data stand for one cycle only, zero otherwise
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         a_rdata_out <= '0;
         c_rdata_out <= '0;
      end else begin
         a_rdata_out <= !a_re_in ? '0 :
                        a_ovr_in ? a_ovr_data_in : mem[a_addr_in];
         c_rdata_out <= !c_re_in ? '0 :
                        c_ovr_in ? c_ovr_data_in : mem[c_addr_in];
      end
   end

endmodule

// file: hw/dnpi_top.sv
`timescale 1ns/1ps
module dnpi_top
   import dnpi_pkg::*;
#(
   parameter int SAMPLE_CYCLES = SAMPLE_CYC,
   parameter int TUNE_CYCLES   = TUNE_CYC
) (
   input  wire logic          core_clk_in,
   input  wire logic          rst_in,
   input  wire dnpi_bus_type  bus_in,
   output logic      [15:0]   bus_rdata_out,
   input  wire logic          cmd_valid_in,
   input  wire logic          cmd_last_in,
   input  wire logic [15:0]   cmd_word_in,
   input  wire logic          reply_req_in,
   output logic               reply_valid_out,
   output logic               reply_last_out,
   output logic      [15:0]   reply_word_out,
   input  wire dnpi_pins_type pins_in,
   output logic               drive_ready_out,
   output logic               start_run_out,
   output logic               start_jog_out,
   output logic               tune_update_out
);

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [1:0] drop_of(input logic [7:0] a);
      return a[7:6];
   endfunction

   function automatic logic accessible(input logic [7:0] a,
                                       input logic       full);
      logic ok;
      ok = full || (drop_of(a) == 2'b00);
      if (a == PROT_IDX) begin
         ok = 1'b0;
      end
      return ok;
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [15:0]   ctrl_live;
      logic [15:0]   ctrl_smp;
      logic [15:0]   cfg;
      logic [31:0]   smp_cnt;
      logic [31:0]   tune_cnt;
      logic [1:0]    start_pend;
      logic          sync_copy;
      logic          ready;
      dnpi_pins_type pin_s1;
      dnpi_pins_type pin_s2;
      logic [4:0]    cmd_idx;
      dnpi_rpl_type  rpl_st;
      logic [3:0]    rpl_idx;
      logic          rpl_valid;
      logic          rpl_last;
      logic          start_run;
      logic          start_jog;
      logic          tune_upd;
   } dnpi_state_type;

   dnpi_state_type q;
   dnpi_state_type d;

   logic        smp_tick;
   logic        tune_tick;
   logic [1:0]  rise;
   logic [1:0]  fire;
   logic        tune_en;
   logic        bus_ok;
   logic [15:0] status_word;
   logic [4:0]  cmd_words;
   logic [3:0]  rpl_words;
   logic        cmd_we;
   logic [7:0]  cmd_addr;
   logic [7:0]  rpl_addr;
   logic        rpl_rd;

   always_comb begin
      smp_tick  = (q.smp_cnt == 32'(SAMPLE_CYCLES - 1));
      tune_tick = (q.tune_cnt == 32'(TUNE_CYCLES - 1));
      bus_ok    = accessible(bus_in.addr, q.cfg[CF_FULL_BIT]);
      cmd_words = q.cfg[CF_CMDX_BIT] ? CMD_LONG : CMD_SHORT;
      rpl_words = q.cfg[CF_RPLX_BIT] ? RPL_LONG : RPL_SHORT;
      cmd_we    = cmd_valid_in && (q.cmd_idx < cmd_words);
      cmd_addr  = CMD_BASE + {3'b000, q.cmd_idx};
      rpl_rd    = (q.rpl_st == RPL_SEND);
      rpl_addr  = RPL_BASE + {4'h0, q.rpl_idx};
      // forced off in control-only mode
      tune_en   = q.ctrl_live[CT_TUNE_BIT] && q.cfg[CF_CMDX_BIT];
      status_word = '0;
      status_word[ST_READY_BIT] = q.ready;
      status_word[ST_FAULT_BIT] = q.pin_s2.fault;
      status_word[ST_SYNC_BIT]  = q.sync_copy;
      status_word[ST_COAST_BIT] = q.pin_s2.coast_brake_stop_input;
      status_word[ST_ILOCK_BIT] = q.pin_s2.interlock;
      // edge between the previous and the new processing sample
      rise = {q.ctrl_live[CT_JOG_BIT] & ~q.ctrl_smp[CT_JOG_BIT],
              q.ctrl_live[CT_RUN_BIT] & ~q.ctrl_smp[CT_RUN_BIT]};
      if (!smp_tick) begin
         rise = 2'b00;
      end
      fire = (q.start_pend | rise) & {2{tune_tick && q.ready}};
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      d = q;
      d.pin_s1 = pins_in;
      d.pin_s2 = q.pin_s1;
      d.smp_cnt  = smp_tick ? '0 : q.smp_cnt + 32'h1;
      d.tune_cnt = tune_tick ? '0 : q.tune_cnt + 32'h1;

      // control word sampled only on the sample tick
      if (smp_tick) begin
         d.ctrl_smp = q.ctrl_live;
      end

      // new edge on a tick survives the clear of the pending flags
      d.start_pend = (tune_tick ? 2'b00 : q.start_pend) | rise;
      if (tune_tick) begin
         d.start_pend = rise;
      end
      d.start_run = fire[0];
      d.start_jog = fire[1];

      d.ready = !q.pin_s2.fault
             && !q.pin_s2.panel_stop
             && q.ctrl_smp[CT_STOP_BIT]
             && q.pin_s2.coast_brake_stop_input
             && q.pin_s2.interlock;

      d.tune_upd = 1'b0;
      if (tune_tick && tune_en) begin
         d.sync_copy = q.ctrl_live[CT_SYNC_BIT];
         d.tune_upd  = 1'b1;
      end

      // explicit writes to the shadowed registers
      if (bus_in.wr && bus_ok && bus_in.addr == CFG_IDX) begin
         d.cfg = bus_in.wdata;
      end
      if (bus_in.wr && bus_ok && bus_in.addr == CTRL_IDX) begin
         d.ctrl_live = bus_in.wdata;
      end

      // poll command: word 0 is the drive control word
      if (cmd_we && q.cmd_idx == 5'h00) begin
         d.ctrl_live = cmd_word_in;
      end
      if (cmd_valid_in) begin
         if (cmd_last_in) begin
            d.cmd_idx = '0;
         end else if (q.cmd_idx != 5'h1f) begin
            d.cmd_idx = q.cmd_idx + 5'h1;
         end
      end

      // poll reply
      d.rpl_valid = rpl_rd;
      d.rpl_last  = rpl_rd && (q.rpl_idx == rpl_words - 4'h1);
      unique case (q.rpl_st)
         RPL_IDLE: begin
            if (reply_req_in) begin
               d.rpl_st  = RPL_SEND;
               d.rpl_idx = '0;
            end
         end
         RPL_SEND: begin
            if (q.rpl_idx == rpl_words - 4'h1) begin
               d.rpl_st = RPL_IDLE;
            end else begin
               d.rpl_idx = q.rpl_idx + 4'h1;
            end
         end
         default: begin
            d.rpl_st = RPL_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         q           <= '0;
         q.ctrl_live <= CTRL_RESET;
         q.ctrl_smp  <= CTRL_RESET;
         q.cfg       <= CFG_RESET;
         q.rpl_st    <= RPL_IDLE;
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // register image
   // ************************************************************
   dnpi_reg_mem #(
      .AW (ADDR_W),
      .DW (DATA_W)
   ) u_mem (
      .core_clk_in   (core_clk_in),
      .rst_in        (rst_in),
      .a_addr_in     (bus_in.addr),
      .a_we_in       (bus_in.wr && bus_ok && bus_in.addr != STATUS_IDX),
      .a_re_in       (bus_in.rd),
      .a_wdata_in    (bus_in.wdata),
      .a_ovr_in      (!bus_ok || bus_in.addr == STATUS_IDX),
      .a_ovr_data_in (bus_ok ? status_word : 16'h0000),
      .a_rdata_out   (bus_rdata_out),
      .b_addr_in     (cmd_addr),
      .b_we_in       (cmd_we),
      .b_wdata_in    (cmd_word_in),
      .c_addr_in     (rpl_addr),
      .c_re_in       (rpl_rd),
      .c_ovr_in      (q.rpl_idx == 4'h0),
      .c_ovr_data_in (status_word),
      .c_rdata_out   (reply_word_out)
   );

   always_comb begin
      reply_valid_out = q.rpl_valid;
      reply_last_out  = q.rpl_last;
      drive_ready_out = q.ready;
      start_run_out   = q.start_run;
      start_jog_out   = q.start_jog;
      tune_update_out = q.tune_upd;
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   AST_SAMPLE_ONLY_ON_TICK: assert property (
      $changed(q.ctrl_smp) |-> $past(smp_tick))
      else $error("control sample moved off its tick");
   AST_START_NEEDS_EDGE: assert property (
      start_run_out |-> $past(q.start_pend[0] | rise[0]))
      else $error("run start without a rising edge");
   AST_START_ON_TUNE_TICK: assert property (
      (start_run_out || start_jog_out) |-> $past(tune_tick))
      else $error("start not aligned to the tune tick");
   AST_READY_FAULT: assert property (
      (q.pin_s2.fault || q.pin_s2.panel_stop) |=> !drive_ready_out)
      else $error("ready while faulted or panel stop pressed");
   AST_READY_STOP: assert property (
      !q.ctrl_smp[CT_STOP_BIT] |=> !drive_ready_out)
      else $error("ready with network stop low");
   AST_READY_TERM: assert property (
      !(q.pin_s2.coast_brake_stop_input && q.pin_s2.interlock)
      |=> !drive_ready_out)
      else $error("ready with a terminal input open");
   AST_READY_SET: assert property (
      (!q.pin_s2.fault && !q.pin_s2.panel_stop && q.ctrl_smp[CT_STOP_BIT]
       && q.pin_s2.coast_brake_stop_input && q.pin_s2.interlock)
      |=> drive_ready_out)
      else $error("ready missing with all conditions met");
   AST_BASIC_HIDDEN: assert property (
      (bus_in.rd && !q.cfg[CF_FULL_BIT] && drop_of(bus_in.addr) != 2'b00)
      |=> bus_rdata_out == 16'h0000)
      else $error("upper drop visible in basic mode");
   AST_PROTECTED: assert property (
      (bus_in.rd && bus_in.addr == PROT_IDX) |=> bus_rdata_out == 16'h0000)
      else $error("protected register readable");
   AST_CMD_SHORT: assert property (
      (cmd_valid_in && !q.cfg[CF_CMDX_BIT] && q.cmd_idx >= CMD_SHORT)
      |-> !cmd_we)
      else $error("extra command word stored in short form");
   AST_REPLY_SHORT: assert property (
      (q.rpl_st == RPL_IDLE && reply_req_in && !q.cfg[CF_RPLX_BIT])
      |=> ##1 reply_valid_out [*8] ##1 !reply_valid_out)
      else $error("short reply is not eight words");
   AST_TUNE_FORCED: assert property (
      tune_update_out |-> $past(q.cfg[CF_CMDX_BIT]))
      else $error("tune update in control-only mode");
   AST_SYNC_COPY: assert property (
      tune_update_out |-> q.sync_copy == $past(q.ctrl_live[CT_SYNC_BIT]))
      else $error("sync bit not copied on tune update");

   COV_RUN_START: cover property (start_run_out);
   COV_JOG_START: cover property (start_jog_out);
   COV_REPLY_LAST: cover property (reply_last_out && q.cfg[CF_RPLX_BIT]);
   COV_TUNE: cover property (tune_update_out);

endmodule

// file: verification/dnpi_master_model.sv
`timescale 1ns/1ps
module dnpi_master_model
   import dnpi_pkg::*;
(
   input  wire logic        core_clk_in,
   output logic             cmd_valid_out,
   output logic             cmd_last_out,
   output logic [15:0]      cmd_word_out,
   output logic             reply_req_out,
   input  wire logic        reply_valid_in,
   input  wire logic        reply_last_in,
   input  wire logic [15:0] reply_word_in
);
   logic [15:0] rx_q [$];
   bit          got_last;

   initial begin
      cmd_valid_out = 1'b0;
      cmd_last_out  = 1'b0;
      cmd_word_out  = 16'h0000;
      reply_req_out = 1'b0;
   end

   // ************************************************************
   // poll command and poll reply
   // ************************************************************
   // caller may send more words than the configured form holds; words past cmd_words are not stored
   task automatic send(input logic [15:0] w [$]);
      for (int i = 0; i < w.size(); i++) begin
         @(posedge core_clk_in);
         cmd_valid_out <= 1'b1;
         cmd_last_out  <= (i == w.size() - 1);
         cmd_word_out  <= w[i];
      end
      @(posedge core_clk_in);
      cmd_valid_out <= 1'b0;
      cmd_last_out  <= 1'b0;
      // released line must not look like a held word
      cmd_word_out  <= ~w[w.size() - 1];
   endtask

   task automatic poll();
      bit done;
      done = 1'b0;
      rx_q.delete();
      @(posedge core_clk_in);
      reply_req_out <= 1'b1;
      @(posedge core_clk_in);
      reply_req_out <= 1'b0;
      for (int i = 0; i < 40 && !done; i++) begin
         @(posedge core_clk_in);
         if (reply_valid_in === 1'b1) begin
            rx_q.push_back(reply_word_in);
            done = reply_last_in;
         end
      end
      // a reply without its last flag shows up as a mismatch
      got_last = done;
   endtask
endmodule

// file: verification/test_drive_network_poll_interface.sv
`timescale 1ns/1ps
module test_drive_network_poll_interface
   import dnpi_pkg::*;
;
   localparam int SC = 20;
   localparam int TC = 100;
   localparam logic [3:0] PINS_OK = 4'b0011;

   logic          core_clk_in;
   logic          rst_in;
   dnpi_bus_type  bus_q;
   logic [15:0]   rdata;
   dnpi_pins_type pins_q;
   logic          cv, cl, rq, rv, rl;
   logic [15:0]   cw, rw;
   logic          ready, s_run, s_jog, tune;
   logic [15:0]   v;
   logic [15:0]   q [$];
   int            err_total;
   int            cmp_count;
   int            c;

   dnpi_top #(.SAMPLE_CYCLES(SC), .TUNE_CYCLES(TC)) dut (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .bus_in(bus_q),
      .bus_rdata_out(rdata), .cmd_valid_in(cv), .cmd_last_in(cl),
      .cmd_word_in(cw), .reply_req_in(rq), .reply_valid_out(rv),
      .reply_last_out(rl), .reply_word_out(rw), .pins_in(pins_q),
      .drive_ready_out(ready), .start_run_out(s_run),
      .start_jog_out(s_jog), .tune_update_out(tune));

   dnpi_master_model m (
      .core_clk_in(core_clk_in), .cmd_valid_out(cv), .cmd_last_out(cl),
      .cmd_word_out(cw), .reply_req_out(rq), .reply_valid_in(rv),
      .reply_last_in(rl), .reply_word_in(rw));

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      bus_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk_in);
      bus_q.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge core_clk_in);
      bus_q <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk_in);
      bus_q.rd <= 1'b0;
      #1 d = rdata;
   endtask

   // window of fixed length: pulse counts, never open-ended
   task automatic count(input int sel, input int n, output int cnt);
      cnt = 0;
      repeat (n) begin
         @(posedge core_clk_in);
         // an unknown pulse counts, so a quiet window cannot hide it
         if (((sel == 0) ? s_run : (sel == 1) ? s_jog : tune) !== 1'b0)
            cnt++;
      end
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_window();
      wr(8'h45, 16'h1234);
      rd(8'h45, v); chk("basic reg 69", 16'h0000, v);
      wr(CFG_IDX, 16'h0001);
      wr(8'h45, 16'h1234);
      wr(8'hc5, 16'hbeef);
      rd(8'h45, v); chk("full reg 69", 16'h1234, v);
      rd(8'hc5, v); chk("drop4 reg 5", 16'hbeef, v);
      wr(PROT_IDX, 16'h0005);
      rd(PROT_IDX, v); chk("protected", 16'h0000, v);
      wr(CFG_IDX, 16'h0000);
      rd(8'hc5, v); chk("basic drop4", 16'h0000, v);
   endtask

   task automatic t_ready();
      m.send('{16'h0002});
      step(2 * SC + 6);
      chk("ready", 16'h0001, {15'h0000, ready});
      wr(STATUS_IDX, 16'hffff);
      rd(STATUS_IDX, v); chk("status", 16'h0c01, v);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk_in);
         pins_q <= PINS_OK ^ (4'h1 << i);
         step(8);
         chk("ready pin", 16'h0000, {15'h0000, ready});
         @(posedge core_clk_in);
         pins_q <= PINS_OK;
         step(8);
         chk("ready back", 16'h0001, {15'h0000, ready});
      end
      m.send('{16'h0000});
      step(2 * SC + 6);
      chk("ready no stop", 16'h0000, {15'h0000, ready});
      m.send('{16'h0002});
      step(2 * SC + 6);
   endtask

   task automatic t_start();
      m.send('{16'h0003});
      count(0, TC + 2 * SC + 10, c);
      chk("run starts", 16'h0001, 16'(c));
      count(0, 2 * TC + 50, c);
      chk("run level", 16'h0000, 16'(c));
      m.send('{16'h0002});
      step(TC + 20);
      m.send('{16'h0006});
      count(1, TC + 2 * SC + 10, c);
      chk("jog starts", 16'h0001, 16'(c));
      m.send('{16'h0002});
      step(TC + 20);
   endtask

   task automatic t_poll();
      wr(8'h24, 16'haaaa);
      wr(8'h0c, 16'h7777);
      m.send('{16'h0002, 16'h1111, 16'h2222, 16'h3333, 16'h5555});
      rd(8'h23, v); chk("cmd word 3", 16'h3333, v);
      rd(8'h24, v); chk("cmd word 4", 16'haaaa, v);
      wr(CFG_IDX, 16'h0002);
      q = '{16'h0002};
      for (int k = 1; k < 26; k++)
         q.push_back(16'h0100 + 16'(k));
      m.send(q);
      rd(8'h39, v); chk("cmd word 25", 16'h0119, v);
      wr(CFG_IDX, 16'h0000);
      m.poll();
      chk("reply len", 16'h0008, 16'(m.rx_q.size()));
      chk("reply last", 16'h0001, {15'h0000, m.got_last});
      if (m.rx_q.size() > 0)
         chk("reply status", 16'h0c01, m.rx_q[0]);
      wr(CFG_IDX, 16'h0004);
      m.poll();
      chk("long reply len", 16'h000d, 16'(m.rx_q.size()));
      chk("long reply last", 16'h0001, {15'h0000, m.got_last});
      if (m.rx_q.size() > 0)
         chk("reply word 12", 16'h7777, m.rx_q[$]);
   endtask

   task automatic t_sync();
      wr(CFG_IDX, 16'h0000);
      m.send('{16'hc002});
      count(2, TC + 30, c);
      chk("tune control only", 16'h0000, 16'(c));
      rd(STATUS_IDX, v); chk("sync bit", 16'h0000, v & 16'h0080);
      wr(CFG_IDX, 16'h0002);
      // one tune period holds exactly one tick, whatever its phase
      count(2, TC, c);
      chk("tune update", 16'h0001, 16'(c));
      rd(STATUS_IDX, v); chk("sync copy", 16'h0080, v & 16'h0080);
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      core_clk_in = 1'b0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end

   initial begin
      repeat (20000) @(posedge core_clk_in);
      err_total++;
      results();
   end

   initial begin
      err_total = 0;
      cmp_count = 0;
      rst_in = 1'b1;
      bus_q = '0;
      pins_q = PINS_OK;
      step(4);
      rst_in <= 1'b0;
      // image memory is not reset; status needs the two pin sync stages
      step(2);
      rd(STATUS_IDX, v); chk("status reset", 16'h0c00, v);
      chk("start reset", 16'h0000, {14'h0000, s_jog, s_run});
      chk("ready reset", 16'h0000, {15'h0000, ready});
      t_window();
      t_ready();
      t_start();
      t_poll();
      t_sync();
      results();
   end
endmodule
